// ---- srs_assertions.sv ----
// port checker for the spindle rotation sequencer
`timescale 1ns/1ps
module srs_assertions
  import srs_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       spindleFaultInput,
  input wire logic       spindleCwDrive,
  input wire logic       spindleCcwDrive,
  input wire logic       spindleStopIndication,
  input wire logic       spindleBrakeDrive,
  input wire logic       linkCwFlag,
  input wire logic       linkCcwFlag,
  input wire logic       spindleEnable,
  input wire srs_lamps_t panelLamps
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic cwRun;
  logic ccwRun;
  assign cwRun = spindleCwDrive | linkCwFlag;
  assign ccwRun = spindleCcwDrive | linkCcwFlag;
  sequence stopRise;
    $rose(spindleStopIndication);
  endsequence
  sequence brakeQuiet;
    !spindleBrakeDrive [*3];
  endsequence
  AST_STOP_MATCH: assert property (spindleStopIndication == !(cwRun | ccwRun))
    else $error("stop indication disagrees with direction");
  AST_LAMPS: assert property (panelLamps == {ccwRun, cwRun, spindleStopIndication})
    else $error("panel lamps disagree with state");
  AST_NO_REVERSE: assert property (!($past(cwRun) && ccwRun) && !($past(ccwRun) && cwRun))
    else $error("direction reversed without stop");
  AST_FAULT_STOP: assert property (spindleFaultInput [*5] |-> spindleStopIndication)
    else $error("fault did not stop spindle");
  AST_BRAKE_STOPPED: assert property (spindleBrakeDrive |-> spindleStopIndication)
    else $error("brake while running");
  AST_BRAKE_WAIT: assert property (stopRise |-> brakeQuiet)
    else $error("brake without delay");
  AST_BRAKE_CANCEL: assert property ($fell(spindleStopIndication) |-> !spindleBrakeDrive)
    else $error("brake kept on start");
  AST_ENABLE: assert property (spindleEnable |-> !spindleStopIndication)
    else $error("enable while stopped");
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
endmodule : srs_assertions

bind srs_sequencer srs_assertions chk (.mclk(mclk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
  .spindleFaultInput(spindleFaultInput), .spindleCwDrive(spindleCwDrive), .spindleCcwDrive(spindleCcwDrive),
  .spindleStopIndication(spindleStopIndication), .spindleBrakeDrive(spindleBrakeDrive),
  .linkCwFlag(linkCwFlag), .linkCcwFlag(linkCcwFlag), .spindleEnable(spindleEnable), .panelLamps(panelLamps));

// ---- srs_drive_model.sv ----
// behavioural spindle drive: fault contact and speed voltage
`timescale 1ns/1ps
module srs_drive_model
(
  input  wire logic mclk,
  input  wire logic cwIn,
  input  wire logic ccwIn,
  input  wire logic faultCmd,
  input  wire logic speedZero,
  output logic      faultOut,
  output logic      voltPos
);
  initial faultOut = 1'b0;
  initial voltPos = 1'b0;
  // voltage exists only while a direction is driven
  always @(posedge mclk)
  begin
    faultOut <= #2 faultCmd;
    voltPos <= #2 (cwIn | ccwIn) & !speedZero;
  end
endmodule : srs_drive_model

// ---- srs_pkg.sv ----
// package for the spindle rotation sequencer: register map, fields, timing
package srs_pkg;

  localparam int unsigned CLK_MHZ = 125;

  // brake timing defaults in milliseconds
  localparam int unsigned BRAKE_DELAY_MS_DEF = 100;
  localparam int unsigned BRAKE_HOLD_MS_DEF  = 500;
  localparam int unsigned CYCLES_PER_MS      = CLK_MHZ * 1000;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_DELAY    = 8'h14;
  localparam logic [7:0] REG_HOLD     = 8'h18;

  // ctrl fields
  localparam int unsigned CTRL_KEEP_RESET = 0;
  localparam int unsigned CTRL_KEEP_PEND  = 1;
  localparam int unsigned CTRL_TYPE_LO    = 2;
  localparam int unsigned CTRL_TYPE_HI    = 3;
  localparam int unsigned CTRL_COOL       = 4;
  localparam int unsigned CTRL_LUBE       = 5;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

  // command fields (write one to issue)
  localparam int unsigned CMD_CW       = 0;
  localparam int unsigned CMD_CCW      = 1;
  localparam int unsigned CMD_STOP     = 2;
  localparam int unsigned CMD_PEND     = 3;
  localparam int unsigned CMD_CNCRESET = 4;
  localparam int unsigned CMD_ESTOP    = 5;

  // interrupt status fields
  localparam int unsigned IRQ_DIR_ALARM   = 0;
  localparam int unsigned IRQ_FAULT_ALARM = 1;
  localparam int unsigned IRQ_BRAKE_DONE  = 2;
  localparam int unsigned IRQ_W           = 3;

  localparam logic [1:0] TYPE_MECH   = 2'h0;
  localparam logic [1:0] TYPE_ANALOG = 2'h1;
  localparam logic [1:0] TYPE_SERIAL = 2'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0]
  {
    SRS_STOP = 3'b001,
    SRS_CW   = 3'b010,
    SRS_CCW  = 3'b100
  } srs_state_t;

  typedef enum logic [2:0]
  {
    SRS_BK_IDLE  = 3'b001,
    SRS_BK_DELAY = 3'b010,
    SRS_BK_HOLD  = 3'b100
  } srs_brake_t;

  // one request from bus or panel
  typedef struct packed
  {
    logic cw;
    logic ccw;
    logic stop;
    logic progEnd;
    logic cncReset;
    logic extStop;
  } srs_req_t;

  // panel lamps
  typedef struct packed
  {
    logic ccwLamp;
    logic cwLamp;
    logic stopLamp;
  } srs_lamps_t;

endpackage : srs_pkg

// ---- srs_sequencer.sv ----
// spindle rotation sequencer with ahb-lite register slave
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int unsigned CNT_W = 32
)
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        panelCwKey,
  input  wire logic        panelCcwKey,
  input  wire logic        panelStopKey,
  input  wire logic        spindleFaultInput,
  input  wire logic        analogVoltagePositive,
  output logic             spindleCwDrive,
  output logic             spindleCcwDrive,
  output logic             spindleStopIndication,
  output logic             spindleBrakeDrive,
  output logic             linkCwFlag,
  output logic             linkCcwFlag,
  output logic             spindleEnable,
  output logic             coolantDrive,
  output logic             lubeDrive,
  output srs_lamps_t       panelLamps,
  output logic             irq
);

  if (CNT_W > 32 || 64'(BRAKE_HOLD_MS_DEF) * CYCLES_PER_MS >= (64'd1 << CNT_W) ||
      64'(BRAKE_DELAY_MS_DEF) * CYCLES_PER_MS >= (64'd1 << CNT_W))
    $error("srs_sequencer: CNT_W too small for default brake times or above 32");

  localparam logic [CNT_W-1:0] DELAY_DEF = CNT_W'(BRAKE_DELAY_MS_DEF * CYCLES_PER_MS);
  localparam logic [CNT_W-1:0] HOLD_DEF  = CNT_W'(BRAKE_HOLD_MS_DEF * CYCLES_PER_MS);

  // two-flop synchronisers for pins
  logic [4:0] pinMeta_r;
  logic [4:0] pinSync_r;
  logic [4:0] pinLast_r;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pinMeta_r <= 5'h00;
      pinSync_r <= 5'h00;
      pinLast_r <= 5'h00;
    end
    else
    begin
      pinMeta_r <= {analogVoltagePositive, spindleFaultInput, panelStopKey, panelCcwKey, panelCwKey};
      pinSync_r <= pinMeta_r;
      pinLast_r <= pinSync_r;
    end
  end
  logic [2:0] keyPress;
  logic       faultRise;
  logic       faultLvl;
  logic       voltPos;
  assign keyPress  = pinSync_r[2:0] & ~pinLast_r[2:0];
  assign faultLvl  = pinSync_r[3];
  assign faultRise = pinSync_r[3] & ~pinLast_r[3];
  assign voltPos   = pinSync_r[4];

  // ahb-lite address phase capture
  logic       dWrite_r;
  logic [7:0] dAddr_r;
  logic       aValid;
  assign aValid = hsel & hready & (htrans == HTRANS_NONSEQ);
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      dWrite_r  <= 1'b0;
      dAddr_r   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dWrite_r  <= aValid & hwrite;
      dAddr_r   <= aValid ? haddr[7:0] : dAddr_r;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software registers
  logic [31:0]      ctrl_r;
  logic [CNT_W-1:0] delay_r;
  logic [CNT_W-1:0] hold_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqStat_r;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_r    <= CTRL_RST;
      delay_r   <= DELAY_DEF;
      hold_r    <= HOLD_DEF;
      irqMask_r <= '0;
    end
    else if (dWrite_r)
    begin
      case (dAddr_r)
        REG_CTRL:     ctrl_r    <= hwdata;
        REG_DELAY:    delay_r   <= hwdata[CNT_W-1:0];
        REG_HOLD:     hold_r    <= hwdata[CNT_W-1:0];
        REG_IRQ_MASK: irqMask_r <= hwdata[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // command pulses from bus and panel merged
  srs_req_t req;
  always_comb
  begin
    req = '0;
    if (dWrite_r && dAddr_r == REG_CMD)
    begin
      req.cw       = hwdata[CMD_CW];
      req.ccw      = hwdata[CMD_CCW];
      req.stop     = hwdata[CMD_STOP];
      req.progEnd  = hwdata[CMD_PEND];
      req.cncReset = hwdata[CMD_CNCRESET];
      req.extStop  = hwdata[CMD_ESTOP];
    end
    req.cw   = req.cw | keyPress[0];
    req.ccw  = req.ccw | keyPress[1];
    req.stop = req.stop | keyPress[2];
  end

  logic keepReset;
  logic keepPend;
  assign keepReset = ctrl_r[CTRL_KEEP_RESET];
  assign keepPend  = ctrl_r[CTRL_KEEP_PEND];

  // rotation state
  srs_state_t state_r;
  srs_state_t state_nxt;
  logic       dirAlarm;
  always_comb
  begin
    state_nxt = state_r;
    dirAlarm  = 1'b0;
    if (req.extStop || faultLvl)
      state_nxt = SRS_STOP;
    else if (req.cncReset && !keepReset)
      state_nxt = SRS_STOP;
    else if (req.progEnd && !keepPend)
      state_nxt = SRS_STOP;
    else if (req.stop)
      state_nxt = SRS_STOP;
    else
    begin
      case (state_r)
        SRS_STOP:
        begin
          if (req.cw)
            state_nxt = SRS_CW;
          else if (req.ccw)
            state_nxt = SRS_CCW;
        end
        SRS_CW:  dirAlarm = req.ccw;
        SRS_CCW: dirAlarm = req.cw;
        default: state_nxt = SRS_STOP;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_r <= SRS_STOP;
    else
      state_r <= state_nxt;
  end

  // direction, stop and lamp outputs all register from state_nxt so they change together
  logic serialMode;
  assign serialMode = (ctrl_r[CTRL_TYPE_HI:CTRL_TYPE_LO] == TYPE_SERIAL);
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      spindleCwDrive        <= 1'b0;
      spindleCcwDrive       <= 1'b0;
      spindleStopIndication <= 1'b1;
      linkCwFlag            <= 1'b0;
      linkCcwFlag           <= 1'b0;
      panelLamps            <= 3'b001;
    end
    else
    begin
      spindleCwDrive        <= (state_nxt == SRS_CW) & ~serialMode;
      spindleCcwDrive       <= (state_nxt == SRS_CCW) & ~serialMode;
      linkCwFlag            <= (state_nxt == SRS_CW) & serialMode;
      linkCcwFlag           <= (state_nxt == SRS_CCW) & serialMode;
      spindleStopIndication <= (state_nxt == SRS_STOP);
      panelLamps            <= {state_nxt == SRS_CCW, state_nxt == SRS_CW, state_nxt == SRS_STOP};
    end
  end

  // spindle enable: analog mode needs positive voltage
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      spindleEnable <= 1'b0;
    else if (ctrl_r[CTRL_TYPE_HI:CTRL_TYPE_LO] == TYPE_ANALOG)
      spindleEnable <= (state_nxt != SRS_STOP) & voltPos;
    else
      spindleEnable <= (state_nxt != SRS_STOP);
  end

  // coolant and lubrication follow ctrl, forced off by controller reset
  logic auxKill_r;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      auxKill_r <= 1'b0;
    else if (req.cncReset && !keepReset)
      auxKill_r <= 1'b1;
    else if (dWrite_r && dAddr_r == REG_CTRL)
      auxKill_r <= 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    coolantDrive <= rstn & ctrl_r[CTRL_COOL] & ~auxKill_r & ~(req.cncReset & ~keepReset);
    lubeDrive    <= rstn & ctrl_r[CTRL_LUBE] & ~auxKill_r & ~(req.cncReset & ~keepReset);
  end

  // brake sequencer
  srs_brake_t       brake_r;
  logic [CNT_W-1:0] brakeCnt_r;
  logic             brakeDone;
  logic             stopEntry;
  assign stopEntry = (state_r != SRS_STOP) && (state_nxt == SRS_STOP);
  always_ff @(posedge mclk)
  begin
    // any start cancels a pending or running brake
    if (!rstn || state_nxt != SRS_STOP)
    begin
      brake_r           <= SRS_BK_IDLE;
      brakeCnt_r        <= '0;
      spindleBrakeDrive <= 1'b0;
    end
    else
    begin
      case (brake_r)
        SRS_BK_IDLE:
        begin
          if (stopEntry)
          begin
            brake_r    <= SRS_BK_DELAY;
            brakeCnt_r <= '0;
          end
        end
        SRS_BK_DELAY:
        begin
          brakeCnt_r <= brakeCnt_r + 1'b1;
          if (brakeCnt_r + 1'b1 >= delay_r)
          begin
            brake_r           <= SRS_BK_HOLD;
            brakeCnt_r        <= '0;
            spindleBrakeDrive <= 1'b1;
          end
        end
        SRS_BK_HOLD:
        begin
          brakeCnt_r <= brakeCnt_r + 1'b1;
          if (brakeCnt_r + 1'b1 >= hold_r)
          begin
            brake_r           <= SRS_BK_IDLE;
            spindleBrakeDrive <= 1'b0;
          end
        end
        default:
        begin
          brake_r           <= SRS_BK_IDLE;
          spindleBrakeDrive <= 1'b0;
        end
      endcase
    end
  end
  assign brakeDone = (brake_r == SRS_BK_HOLD) && (brakeCnt_r + 1'b1 >= hold_r) && (state_nxt == SRS_STOP);

  // sticky interrupt status, set wins over write-one clear
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClr;
  always_comb
  begin
    irqSet                  = '0;
    irqSet[IRQ_DIR_ALARM]   = dirAlarm;
    irqSet[IRQ_FAULT_ALARM] = faultRise;
    irqSet[IRQ_BRAKE_DONE]  = brakeDone;
    irqClr = (dWrite_r && dAddr_r == REG_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;
  end
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      irqStat_r <= '0;
    else
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
  end
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
  end

  // read data
  logic [31:0] statusWord;
  assign statusWord = {20'h00000, faultLvl, brake_r == SRS_BK_HOLD, spindleBrakeDrive,
                       spindleEnable, linkCcwFlag, linkCwFlag, 3'(state_r), spindleStopIndication,
                       spindleCcwDrive, spindleCwDrive};
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (aValid && !hwrite)
    begin
      case (haddr[7:0])
        REG_CTRL:     hrdata <= ctrl_r;
        REG_STATUS:   hrdata <= statusWord;
        REG_IRQ_STAT: hrdata <= 32'(irqStat_r);
        REG_IRQ_MASK: hrdata <= 32'(irqMask_r);
        REG_DELAY:    hrdata <= 32'(delay_r);
        REG_HOLD:     hrdata <= 32'(hold_r);
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : srs_sequencer

// ---- srs_sequencer_test.sv ----
// self-checking bench for the spindle rotation sequencer
`timescale 1ns/1ps
module srs_sequencer_test
  import srs_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, hwrite = 1'b0, hready, hresp, faultCmd = 1'b0, speedZero = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic panelCwKey = 1'b0, panelCcwKey = 1'b0, panelStopKey = 1'b0;
  logic spindleFaultInput, analogVoltagePositive, spindleCwDrive, spindleCcwDrive;
  logic spindleStopIndication, spindleBrakeDrive, linkCwFlag, linkCcwFlag;
  logic spindleEnable, coolantDrive, lubeDrive, irq;
  srs_lamps_t panelLamps;
  int badCount = 0, testsRun = 0, cycles = 0, n;

  srs_sequencer dut (.mclk, .rstn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .panelCwKey, .panelCcwKey, .panelStopKey,
    .spindleFaultInput, .analogVoltagePositive, .spindleCwDrive, .spindleCcwDrive,
    .spindleStopIndication, .spindleBrakeDrive, .linkCwFlag, .linkCcwFlag, .spindleEnable,
    .coolantDrive, .lubeDrive, .panelLamps, .irq);
  srs_drive_model drive (.mclk, .cwIn(spindleCwDrive), .ccwIn(spindleCcwDrive), .faultCmd,
    .speedZero, .faultOut(spindleFaultInput), .voltPos(analogVoltagePositive));

  always #4 mclk = ~mclk;

  task finalReport;
    $display("checks %0d, errors %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finalReport

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      badCount++;
      finalReport();
    end
  end

  task chk(input logic ok, input string m);
    testsRun++;
    if (ok !== 1'b1)
    begin
      badCount++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task cmd(input int b);
    bus(1'b1, REG_CMD, 32'h1 << b);
    cyc(2);
  endtask : cmd

  task st(input logic c, input logic cc, input logic s, input string m);
    chk({spindleCwDrive, spindleCcwDrive, spindleStopIndication} === {c, cc, s} && panelLamps === {cc, c, s}, m);
  endtask : st

  task press(input logic [2:0] k);
    @(posedge mclk);
    {panelCcwKey, panelCwKey, panelStopKey} <= k;
    repeat (4) @(posedge mclk);
    {panelCcwKey, panelCwKey, panelStopKey} <= 3'h0;
    cyc(3);
  endtask : press

  task tBrake;
    cmd(CMD_CW);
    st(1, 0, 0, "cw start");
    cmd(CMD_STOP);
    st(0, 0, 1, "stop");
    for (n = 0; n < 40 && spindleBrakeDrive !== 1'b1; n++)
      cyc(1);
    // delay of 4 programmed, 2 of them already spent inside cmd
    chk(n == 2, "brake delay");
    for (n = 0; n < 40 && spindleBrakeDrive === 1'b1; n++)
      cyc(1);
    chk(n == 6, "brake hold");
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q[IRQ_BRAKE_DONE] === 1'b1 && irq === 1'b1, "brake release event");
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    cyc(2);
    chk(irq === 1'b0, "status clear");
  endtask : tBrake

  task tReverse;
    cmd(CMD_CCW);
    cmd(CMD_CW);
    st(0, 1, 0, "reverse refused");
    chk(irq === 1'b1, "direction alarm irq");
    bus(1'b1, REG_IRQ_MASK, 32'h6);
    cyc(2);
    chk(irq === 1'b0, "alarm masked");
    bus(1'b1, REG_IRQ_STAT, 32'h7);
    bus(1'b1, REG_IRQ_MASK, 32'h7);
    bus(1'b1, REG_CTRL, 32'h31);
    cmd(CMD_CNCRESET);
    st(0, 1, 0, "reset keeps");
    chk(coolantDrive === 1'b1 && lubeDrive === 1'b1, "coolant kept");
    bus(1'b1, REG_CTRL, 32'h30);
    cmd(CMD_CNCRESET);
    st(0, 0, 1, "reset stops");
    chk(coolantDrive === 1'b0 && lubeDrive === 1'b0, "coolant off");
    bus(1'b1, REG_CTRL, 32'h2);
    cmd(CMD_CW);
    cmd(CMD_PEND);
    st(1, 0, 0, "end keeps");
    bus(1'b1, REG_CTRL, 32'h0);
    cmd(CMD_PEND);
    st(0, 0, 1, "end stops");
  endtask : tReverse

  task tFault;
    cmd(CMD_CCW);
    faultCmd <= 1'b1;
    cyc(6);
    st(0, 0, 1, "fault stops");
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[11] === 1'b1, "fault level flag");
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q[IRQ_FAULT_ALARM] === 1'b1, "fault alarm");
    cmd(CMD_CW);
    st(0, 0, 1, "start blocked");
    faultCmd <= 1'b0;
    cyc(6);
    cmd(CMD_CW);
    cmd(CMD_ESTOP);
    st(0, 0, 1, "external stop");
  endtask : tFault

  task tModes;
    press(3'b100);
    st(0, 1, 0, "panel ccw");
    press(3'b010);
    st(0, 1, 0, "panel reverse refused");
    press(3'b001);
    st(0, 0, 1, "panel stop");
    bus(1'b1, REG_CTRL, 32'h8);
    cmd(CMD_CW);
    chk(linkCwFlag === 1'b1 && spindleCwDrive === 1'b0 && spindleStopIndication === 1'b0, "serial cw");
    cmd(CMD_STOP);
    cmd(CMD_CCW);
    chk(linkCcwFlag === 1'b1 && spindleCcwDrive === 1'b0, "serial ccw");
    cmd(CMD_STOP);
    bus(1'b1, REG_CTRL, 32'h4);
    cmd(CMD_CW);
    cyc(2);
    chk(spindleEnable === 1'b1, "analog enable");
    speedZero <= 1'b1;
    cyc(4);
    chk(spindleEnable === 1'b0, "zero voltage");
    cmd(CMD_STOP);
    bus(1'b0, 8'h40, 32'h0);
    chk(q === 32'h0, "unmapped read");
    bus(1'b0, REG_HOLD, 32'h0);
    chk(q === 32'h6, "hold readback");
  endtask : tModes

  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    cyc(1);
    st(0, 0, 1, "power-up");
    chk(spindleBrakeDrive === 1'b0 && irq === 1'b0, "idle after reset");
    bus(1'b1, REG_DELAY, 32'h4);
    bus(1'b1, REG_HOLD, 32'h6);
    bus(1'b1, REG_IRQ_MASK, 32'h7);
    tBrake();
    tReverse();
    tFault();
    tModes();
    finalReport();
  end
endmodule : srs_sequencer_test
